// ---- hw/ccca_charger_cmd.sv ----
// Purpose: management bus slave, charge current decode, alarm lockout, status and alert
// Assumes: bus clock and all analog status pins are asynchronous to mclk
// Notes:   alert identifier is an arbitrary neutral value
//
// Notes on behaviour
// - six-bit current code steers the switching regulator current limit
// - strap picks code bits D9..D5, D10..D5 or D11..D6; low five bits trickle
// - strap at rail: code bit zero is one whenever D5 is one
// - over-range word saturates code (62 or 63) and sets over-range status
// - word up to 0x001F gives code zero and regulator off
// - regulator off holds high-side gate to switch node, low-side gate low
// - charge-off, lockout or qualified overheat: regulator off, code held
// - qualified overheat is overheat AND shutdown enable AND NOT under-range
// - nonzero code sets trickle source to full scale; charge-off, lockout or qualified overheat set it to zero
// - power-on charge word is 0x000C: code zero, trickle weights three and two
// - pack absent returns charge word to its power-on value
// - alarm write 0x16 with D15, D14 or D12 set raises lockout
// - lockout holds until pack absent or mode write with restore bit
// - lockout keeps regulator and trickle source off
// - read word 0x13 returns sixteen-bit status word
// - overheat and lockout latches clear on pack absent or restore
// - alert low on supply arrival, and on unmasked pack or input-low change
// - alert holds until status read or alert-response receive byte
// - alert-response receive byte answers a fixed identifier byte
// - host writes charge word with write word 0x14, milliamps
// - mode bit 5 masks pack alerts, bit 6 masks input-low alerts
`timescale 1ns/1ns
module ccca_charger_cmd
	import ccca_pkg::*;
#(
	parameter logic [7:0] ALERT_ID = 8'h5A   // arbitrary identifier value
)
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// management bus pins, data is open drain
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut,
	output logic            sdaOe,
	output logic            alertN,
	// straps and analog status
	input  wire logic [1:0] strapSel,
	input  wire logic       packDetect,
	input  wire logic       inputLow,
	input  wire logic       supplyIn,
	input  wire logic       overheatIn,
	input  wire logic       underrangeIn,
	// power stage controls
	output logic [5:0]      rangeCodeBits,
	output logic [4:0]      trickleWeightBits,
	output logic            swRegOn,
	output logic            gateHold
);

	////////////////////////////////////////////////////////////////////////////////
	// current code mapping: {over-range, code}
	function automatic logic [6:0] mapCode(input logic [15:0] w, input logic [1:0] s);
		logic       ovr;
		logic [5:0] cd;
		ovr = 1'b0;
		cd  = 6'h00;
		if (s == STRAP_GND)
		begin
			ovr = |w[15:10];
			cd  = ovr ? CODE_SAT_GND : {w[9:5], 1'b0};
		end
		else if (s == STRAP_OPEN)
		begin
			ovr = |w[15:11];
			cd  = ovr ? CODE_SAT : w[10:5];
		end
		else
		begin
			ovr = |w[15:12];
			cd  = ovr ? CODE_SAT : {w[11:7], w[6] | w[5]};
		end
		return {ovr, cd};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [SYNC_W-1:0] sync1_ff;
	logic [SYNC_W-1:0] sync2_ff;
	logic              sclPrev_ff;
	logic              sdaPrev_ff;
	logic              packPrev_ff;
	logic              lowPrev_ff;
	logic              supPrev_ff;
	ccca_state_t       state_ff;
	ccca_state_t       nxt_state;
	logic [3:0]        bitCnt_ff;
	logic [3:0]        nxt_bitCnt;
	logic [7:0]        shift_ff;
	logic [7:0]        nxt_shift;
	logic [7:0]        cmd_ff;
	logic [7:0]        nxt_cmd;
	logic [7:0]        lo_ff;
	logic [7:0]        nxt_lo;
	logic [15:0]       txWord_ff;
	logic [15:0]       nxt_txWord;
	logic [7:0]        txShift_ff;
	logic [7:0]        nxt_txShift;
	logic              txIdx_ff;
	logic              nxt_txIdx;
	logic              nack_ff;
	logic              nxt_nack;
	logic              sdaOe_ff;
	logic              nxt_sdaOe;
	logic              sdaOut_ff;
	logic              wrStb;
	logic              rdClr;
	logic [15:0]       mode_ff;
	logic [15:0]       curWord_ff;
	logic              lockout_ff;
	logic              hot_ff;
	logic              overRange_ff;
	logic              alertPend_ff;
	logic              nxt_alertPend;
	logic              alertN_ff;
	logic [5:0]        rangeCode_ff;
	logic [4:0]        trickle_ff;
	logic              swRegOn_ff;
	logic              gateHold_ff;

	////////////////////////////////////////////////////////////////////////////////
	// two-stage synchronisers for every pin input
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sync1_ff <= SYNC_RST;
			sync2_ff <= SYNC_RST;
		end
		else
		begin
			sync1_ff <= {sclIn, sdaIn, strapSel, packDetect, inputLow, supplyIn,
				overheatIn, underrangeIn};
			sync2_ff <= sync1_ff;
		end
	end

	// synchronised views
	wire       sclS  = sync2_ff[8];
	wire       sdaS  = sync2_ff[7];
	wire [1:0] strapS = sync2_ff[6:5];
	wire       packS = sync2_ff[4];
	wire       lowS  = sync2_ff[3];
	wire       supS  = sync2_ff[2];
	wire       hotS  = sync2_ff[1];
	wire       urS   = sync2_ff[0];

	// previous samples for edge detection
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			sclPrev_ff  <= 1'b1;
			sdaPrev_ff  <= 1'b1;
			packPrev_ff <= 1'b0;
			lowPrev_ff  <= 1'b0;
			supPrev_ff  <= 1'b0;
		end
		else
		begin
			sclPrev_ff  <= sclS;
			sdaPrev_ff  <= sdaS;
			packPrev_ff <= packS;
			lowPrev_ff  <= lowS;
			supPrev_ff  <= supS;
		end
	end

	// bus line events
	wire sclRise   = sclS & ~sclPrev_ff;
	wire sclFall   = ~sclS & sclPrev_ff;
	wire startCond = sclS & sclPrev_ff & sdaPrev_ff & ~sdaS;
	wire stopCond  = sclS & sclPrev_ff & ~sdaPrev_ff & sdaS;
	wire busActive = (state_ff != ST_IDLE) && (state_ff != ST_IGN);

	////////////////////////////////////////////////////////////////////////////////
	// address and command decode, shift_ff holds the last byte through its ack
	wire devWr     = (shift_ff[7:1] == DEV_ADDR) & ~shift_ff[0];
	wire devRdSts  = (shift_ff[7:1] == DEV_ADDR) & shift_ff[0] & (cmd_ff == CMD_STATUS);
	wire araRd     = (shift_ff[7:1] == ALERT_RESP_ADDR) & shift_ff[0];
	wire addrHit   = devWr | devRdSts | araRd;
	wire ackWanted = (state_ff == ST_ADDR) ? addrHit : (state_ff != ST_RD);
	wire [15:0] wrWord = {shift_ff, lo_ff};
	wire [15:0] statusWord;

	////////////////////////////////////////////////////////////////////////////////
	// bus sequencer next state: bits shift on clock rise, data changes on clock fall
	always_comb
	begin
		nxt_state   = state_ff;
		nxt_bitCnt  = bitCnt_ff;
		nxt_shift   = shift_ff;
		nxt_cmd     = cmd_ff;
		nxt_lo      = lo_ff;
		nxt_txWord  = txWord_ff;
		nxt_txShift = txShift_ff;
		nxt_txIdx   = txIdx_ff;
		nxt_nack    = nack_ff;
		nxt_sdaOe   = sdaOe_ff;
		wrStb       = 1'b0;
		rdClr       = 1'b0;
		if (stopCond)
		begin
			nxt_state = ST_IDLE;
			nxt_sdaOe = 1'b0;
		end
		else if (startCond)
		begin
			nxt_state  = ST_ADDR;
			nxt_bitCnt = 4'h0;
			nxt_sdaOe  = 1'b0;
		end
		else if (sclRise && busActive && bitCnt_ff < BIT_END)
		begin
			if (bitCnt_ff < BIT_ACK)
				nxt_shift = {shift_ff[6:0], sdaS};
			else if (state_ff == ST_RD)
				nxt_nack = sdaS;
			nxt_bitCnt = bitCnt_ff + 4'h1;
		end
		else if (sclFall && busActive)
		begin
			if (bitCnt_ff == BIT_ACK)
				nxt_sdaOe = ackWanted;
			else if (bitCnt_ff == BIT_END)
			begin
				nxt_bitCnt = 4'h0;
				nxt_sdaOe  = 1'b0;
				unique case (state_ff)
					ST_ADDR:
					begin
						if (devWr)
							nxt_state = ST_CMD;
						else if (devRdSts || araRd)
						begin
							nxt_state   = ST_RD;
							rdClr       = 1'b1;
							nxt_txIdx   = araRd;
							nxt_txWord  = devRdSts ? statusWord : {8'h00, ALERT_ID};
							nxt_txShift = {nxt_txWord[6:0], 1'b0};
							nxt_sdaOe   = ~nxt_txWord[7];
						end
						else
							nxt_state = ST_IGN;
					end
					ST_CMD:
					begin
						nxt_cmd   = shift_ff;
						nxt_state = ST_WLO;
					end
					ST_WLO:
					begin
						nxt_lo    = shift_ff;
						nxt_state = ST_WHI;
					end
					ST_WHI:
					begin
						wrStb     = 1'b1;
						nxt_state = ST_IGN;
					end
					ST_RD:
					begin
						if (nack_ff || txIdx_ff)
							nxt_state = ST_IGN;
						else
						begin
							nxt_txIdx   = 1'b1;
							nxt_txShift = {txWord_ff[14:8], 1'b0};
							nxt_sdaOe   = ~txWord_ff[15];
						end
					end
					default:
						nxt_state = ST_IGN;
				endcase
			end
			else if (state_ff == ST_RD && bitCnt_ff != 4'h0)
			begin
				nxt_sdaOe   = ~txShift_ff[7];
				nxt_txShift = {txShift_ff[6:0], 1'b0};
			end
		end
	end

	// bus sequencer registers
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_ff   <= ST_IDLE;
			bitCnt_ff  <= 4'h0;
			shift_ff   <= 8'h00;
			cmd_ff     <= 8'h00;
			lo_ff      <= 8'h00;
			txWord_ff  <= 16'h0000;
			txShift_ff <= 8'h00;
			txIdx_ff   <= 1'b0;
			nack_ff    <= 1'b0;
			sdaOe_ff   <= 1'b0;
			sdaOut_ff  <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			bitCnt_ff  <= nxt_bitCnt;
			shift_ff   <= nxt_shift;
			cmd_ff     <= nxt_cmd;
			lo_ff      <= nxt_lo;
			txWord_ff  <= nxt_txWord;
			txShift_ff <= nxt_txShift;
			txIdx_ff   <= nxt_txIdx;
			nack_ff    <= nxt_nack;
			sdaOe_ff   <= nxt_sdaOe;
			sdaOut_ff  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// write decode and latch clear conditions
	wire wrMode    = wrStb & (cmd_ff == CMD_MODE);
	wire wrCur     = wrStb & (cmd_ff == CMD_CURRENT);
	wire wrAlarm   = wrStb & (cmd_ff == CMD_ALARM);
	wire restore   = wrMode & wrWord[MODE_RESTORE];
	wire clrLatch  = ~packS | restore;
	wire lockSet   = wrAlarm & (wrWord[ALARM_BIT_A] | wrWord[ALARM_BIT_B] |
		wrWord[ALARM_BIT_C]);
	wire hotQual   = hot_ff & mode_ff[MODE_OVERHEAT_SHUTDOWN_EN] & ~urS;
	wire inhibit   = mode_ff[MODE_CHG_OFF] | lockout_ff | hotQual;
	wire [6:0] mapped = mapCode(curWord_ff, strapS);
	wire codeLive  = |mapped[5:0];
	wire swOn      = ~inhibit & (|curWord_ff[15:5]);

	// mode word
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			mode_ff <= MODE_RST;
		else if (wrMode)
			mode_ff <= wrWord;
	end

	// charge current word, reloaded while the pack is absent
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			curWord_ff <= CUR_RST;
		else if (clrLatch)
			curWord_ff <= CUR_RST;
		else if (wrCur)
			curWord_ff <= wrWord;
	end

	// latched lockout and overheat, a set in the clearing cycle wins
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			lockout_ff <= 1'b0;
			hot_ff     <= 1'b0;
		end
		else
		begin
			lockout_ff <= lockSet | (lockout_ff & ~clrLatch);
			hot_ff     <= hotS | (hot_ff & ~clrLatch);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// power stage outputs
	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			rangeCode_ff <= 6'h00;
			overRange_ff <= 1'b0;
			trickle_ff   <= 5'h00;
			swRegOn_ff   <= 1'b0;
			gateHold_ff  <= 1'b1;
		end
		else
		begin
			if (!inhibit)
			begin
				rangeCode_ff <= mapped[5:0];
				overRange_ff <= mapped[6];
			end
			if (inhibit || curWord_ff == 16'h0000)
				trickle_ff <= 5'h00;
			else if (codeLive)
				trickle_ff <= TRICKLE_FULL;
			else
				trickle_ff <= curWord_ff[4:0];
			swRegOn_ff  <= swOn;
			gateHold_ff <= ~swOn;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status word returned by the status read
	assign statusWord = (16'h0001 << STS_CHG_OFF) & {16{mode_ff[MODE_CHG_OFF]}}
		| (16'h0001 << STS_MASTER) & 16'h0000
		| (16'h0001 << STS_CUR_OR) & {16{overRange_ff}}
		| (16'h0001 << STS_UNDERR) & {16{urS}}
		| (16'h0001 << STS_HOT) & {16{hot_ff}}
		| (16'h0001 << STS_LOCKOUT) & {16{lockout_ff}}
		| (16'h0001 << STS_INPUT_LOW) & {16{lowS}}
		| (16'h0001 << STS_PACK) & {16{packS}}
		| (16'h0001 << STS_SUPPLY) & {16{supS}};

	////////////////////////////////////////////////////////////////////////////////
	// alert: new events win over a clear in the same cycle
	wire supRise   = supS & ~supPrev_ff;
	wire packEvt   = (packS ^ packPrev_ff) & ~mode_ff[MODE_PACK_MASK];
	wire lowEvt    = (lowS ^ lowPrev_ff) & ~mode_ff[MODE_LOW_MASK];
	assign nxt_alertPend = supRise | packEvt | lowEvt | (alertPend_ff & ~rdClr);

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			alertPend_ff <= 1'b0;
			alertN_ff    <= 1'b1;
		end
		else
		begin
			alertPend_ff <= nxt_alertPend;
			alertN_ff    <= ~nxt_alertPend;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign sdaOut            = sdaOut_ff;
	assign sdaOe             = sdaOe_ff;
	assign alertN            = alertN_ff;
	assign rangeCodeBits     = rangeCode_ff;
	assign trickleWeightBits = trickle_ff;
	assign swRegOn           = swRegOn_ff;
	assign gateHold          = gateHold_ff;

endmodule

// ---- pkg/ccca_pkg.sv ----
// Purpose: shared constants and types for the charger current command and alert block
// Assumes: management bus addresses given in 7-bit form, data words low byte first
// Notes:   status bit positions other than charge-off and the fixed zero are local choices
package ccca_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// bus addresses and command codes
	localparam logic [6:0] DEV_ADDR        = 7'h09;  // charger address
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;  // alert-response, 0x19 with read bit
	localparam logic [7:0] CMD_MODE        = 8'h12;  // mode_cmd
	localparam logic [7:0] CMD_STATUS      = 8'h13;  // status_query_cmd, charger_state_word
	localparam logic [7:0] CMD_CURRENT     = 8'h14;  // set_current_cmd, charge_current_word
	localparam logic [7:0] CMD_VOLTAGE     = 8'h15;  // set_voltage_cmd, accepted and ignored
	localparam logic [7:0] CMD_ALARM       = 8'h16;  // alarm_cmd, alarm_notice_word

	////////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] CUR_RST  = 16'h000C;    // charge_current_word power-on value
	localparam logic [15:0] MODE_RST = 16'h0440;    // shutdown enable and input-low mask set

	////////////////////////////////////////////////////////////////////////////////
	// mode word fields
	localparam int MODE_CHG_OFF   = 0;
	localparam int MODE_RESTORE   = 2;
	localparam int MODE_PACK_MASK = 5;
	localparam int MODE_LOW_MASK  = 6;
	localparam int MODE_OVERHEAT_SHUTDOWN_EN  = 10;

	////////////////////////////////////////////////////////////////////////////////
	// alarm word bits that lock charging out
	localparam int ALARM_BIT_A = 15;
	localparam int ALARM_BIT_B = 14;
	localparam int ALARM_BIT_C = 12;

	////////////////////////////////////////////////////////////////////////////////
	// status word fields
	localparam int STS_CHG_OFF   = 0;
	localparam int STS_MASTER    = 1;
	localparam int STS_CUR_OR    = 4;
	localparam int STS_UNDERR    = 8;
	localparam int STS_HOT       = 9;
	localparam int STS_LOCKOUT   = 12;
	localparam int STS_INPUT_LOW = 13;
	localparam int STS_PACK      = 14;
	localparam int STS_SUPPLY    = 15;

	////////////////////////////////////////////////////////////////////////////////
	// range strap encodings and code limits
	localparam logic [1:0] STRAP_GND  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [5:0] CODE_SAT_GND = 6'h3E;  // 62
	localparam logic [5:0] CODE_SAT     = 6'h3F;  // 63
	localparam logic [4:0] TRICKLE_FULL = 5'h1F;

	////////////////////////////////////////////////////////////////////////////////
	// synchroniser layout and bus sequencer states
	localparam int          SYNC_W   = 9;
	localparam logic [8:0]  SYNC_RST = 9'h180;    // clock and data lines idle high
	localparam logic [3:0]  BIT_ACK  = 4'h8;
	localparam logic [3:0]  BIT_END  = 4'h9;

	typedef enum logic [6:0]
	{
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_CMD  = 7'h04,
		ST_WLO  = 7'h08,
		ST_WHI  = 7'h10,
		ST_RD   = 7'h20,
		ST_IGN  = 7'h40
	} ccca_state_t;

endpackage

// ---- dv/ccca_charger_cmd_assertions.sv ----
// Purpose: port-level checks for the charger command and alert block
// Assumes: single mclk domain, sys_rst synchronous active high
// Notes:   bound into every ccca_charger_cmd instance
`timescale 1ns/1ns
module ccca_charger_cmd_assertions
	import ccca_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       sys_rst,
	// bus pins
	input wire logic       sclIn,
	input wire logic       sdaIn,
	input wire logic       sdaOut,
	input wire logic       sdaOe,
	input wire logic       alertN,
	// straps and status
	input wire logic [1:0] strapSel,
	input wire logic       packDetect,
	input wire logic       inputLow,
	input wire logic       supplyIn,
	input wire logic       overheatIn,
	input wire logic       underrangeIn,
	// power stage
	input wire logic [5:0] rangeCodeBits,
	input wire logic [4:0] trickleWeightBits,
	input wire logic       swRegOn,
	input wire logic       gateHold
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////
	// power stage relations
	AST_GATE_HOLD: assert property (!swRegOn |-> gateHold)
		else $error("gate not held with regulator off");
	AST_GATE_RUN: assert property (swRegOn |-> !gateHold)
		else $error("gate held with regulator on");
	AST_CODE_NZ: assert property (swRegOn |-> rangeCodeBits != 6'h00)
		else $error("regulator on with zero code");
	AST_TRICKLE_FULL: assert property (swRegOn |-> trickleWeightBits == TRICKLE_FULL)
		else $error("trickle not full scale with code set");
	AST_GND_LSB: assert property ((strapSel == STRAP_GND)[*8] ##0 swRegOn |-> !rangeCodeBits[0])
		else $error("ground strap code bit zero set");

	////////////////////////////////////////////////
	// bus pin and alert relations
	AST_SDA_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("data drive changed while bus clock high");
	AST_SDA_LOW: assert property (sdaOe |-> !sdaOut)
		else $error("data driven high");
	AST_SUPPLY_ALERT: assert property ($rose(supplyIn) |-> ##[1:8] !alertN)
		else $error("no alert after supply arrival");

	// main scenarios reached
	cover property ($rose(swRegOn));
	cover property ($fell(alertN));
	cover property ($rose(alertN));
	cover property ($rose(sdaOe));
endmodule

bind ccca_charger_cmd ccca_charger_cmd_assertions ccca_charger_cmd_assertions_inst (
	.mclk(mclk), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .alertN(alertN), .strapSel(strapSel),
	.packDetect(packDetect), .inputLow(inputLow), .supplyIn(supplyIn),
	.overheatIn(overheatIn), .underrangeIn(underrangeIn),
	.rangeCodeBits(rangeCodeBits), .trickleWeightBits(trickleWeightBits),
	.swRegOn(swRegOn), .gateHold(gateHold)
);

// ---- dv/ccca_host_model.sv ----
// Purpose: host bus controller model for the charger bus pins
// Assumes: frames start just after a falling mclk edge
// Notes:   bus clock 800 ns, held high between frames
`timescale 1ns/1ns
module ccca_host_model
(
	// bus pins
	output logic      scl,
	output logic      sdaDrv,
	input wire logic  sdaLine
);
	// idle bus
	initial
	begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	////////////////////////////////////////////////
	// bit and frame primitives
	task automatic bitOut(input logic b);
		sdaDrv = b;
		#200 scl = 1'b1;
		#400 scl = 1'b0;
		#200;
	endtask

	// release data, sample it while clock high
	task automatic bitIn(output logic b);
		sdaDrv = 1'b1;
		#200 scl = 1'b1;
		#200 b = sdaLine;
		#200 scl = 1'b0;
		#200;
	endtask

	task automatic start();
		sdaDrv = 1'b1;
		#200 scl = 1'b1;
		#200 sdaDrv = 1'b0;
		#200 scl = 1'b0;
		#200;
	endtask

	task automatic stop();
		sdaDrv = 1'b0;
		#200 scl = 1'b1;
		#200 sdaDrv = 1'b1;
		#200;
	endtask

	task automatic wrByte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			bitOut(b[i]);
		bitIn(a);
		ack = !a;
	endtask

	task automatic rdByte(input logic last, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			bitIn(d[i]);
		bitOut(last);
	endtask

	////////////////////////////////////////////////
	// transactions, low byte first
	task automatic writeWord(input logic [7:0] a, input logic [7:0] c,
		input logic [15:0] w, output logic [3:0] ak);
		start();
		wrByte(a, ak[3]);
		wrByte(c, ak[2]);
		wrByte(w[7:0], ak[1]);
		wrByte(w[15:8], ak[0]);
		stop();
	endtask

	task automatic readWord(input logic [7:0] a, input logic [7:0] c,
		output logic [15:0] w, output logic [2:0] ak);
		start();
		wrByte(a, ak[2]);
		wrByte(c, ak[1]);
		start();
		wrByte(a | 8'h01, ak[0]);
		rdByte(1'b0, w[7:0]);
		rdByte(1'b1, w[15:8]);
		stop();
	endtask

	task automatic recvByte(input logic [7:0] a, output logic [7:0] d, output logic ack);
		start();
		wrByte(a, ack);
		rdByte(1'b1, d);
		stop();
	endtask
endmodule

// ---- dv/ccca_charger_cmd_bench.sv ----
// Purpose: self-checking bench for the charger command and alert block
// Assumes: host model drives the bus, bench drives straps and status pins
// Notes:   inputs change on falling mclk edges
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end
module ccca_charger_cmd_bench;
	import ccca_pkg::*;

	localparam logic [7:0] AID = 8'h5A;  // arbitrary identifier value
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        scl, sdaDrv, sdaOut, sdaOe, alertN, swRegOn, gateHold;
	logic        packDetect = 1'b1, inputLow = 1'b0, supplyIn = 1'b1;
	logic        overheatIn = 1'b0, underrangeIn = 1'b0;
	logic [1:0]  strapSel = STRAP_GND;
	logic [5:0]  rangeCodeBits;
	logic [4:0]  trickleWeightBits;
	logic [15:0] sts;
	logic [7:0]  byt;
	logic [3:0]  ak;
	logic [2:0]  ak3;
	int          err_count = 0, checks_done = 0, cycles = 0;
	wire logic   sdaLine = sdaDrv & ~sdaOe;  // pulled up unless pulled low

	////////////////////////////////////////////////
	// design, host and clock
	ccca_charger_cmd #(.ALERT_ID(AID)) ccca_charger_cmd_inst (
		.mclk(mclk), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .alertN(alertN), .strapSel(strapSel),
		.packDetect(packDetect), .inputLow(inputLow), .supplyIn(supplyIn),
		.overheatIn(overheatIn), .underrangeIn(underrangeIn),
		.rangeCodeBits(rangeCodeBits), .trickleWeightBits(trickleWeightBits),
		.swRegOn(swRegOn), .gateHold(gateHold));
	ccca_host_model ccca_host_model_inst (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

	always #50 mclk = ~mclk;

	// hang guard
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			err_count++;
			conclude();
		end
	end

	////////////////////////////////////////////////
	// shared helpers
	task automatic settle();
		repeat (6) @(negedge mclk);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] w);
		ccca_host_model_inst.writeWord({DEV_ADDR, 1'b0}, c, w, ak);
		`CHK("wrAck", 4'hF, ak)
		settle();
	endtask

	task automatic rd();
		ccca_host_model_inst.readWord({DEV_ADDR, 1'b0}, CMD_STATUS, sts, ak3);
		`CHK("rdAck", 3'h7, ak3)
		settle();
	endtask

	task automatic outs(input logic [5:0] c, input logic on, input logic [4:0] t);
		`CHK("code", c, rangeCodeBits)
		`CHK("regOn", on, swRegOn)
		`CHK("trickle", t, trickleWeightBits)
		`CHK("gate", ~on, gateHold)
	endtask

	task automatic alertAck();
		ccca_host_model_inst.recvByte({ALERT_RESP_ADDR, 1'b1}, byt, ak[0]);
		`CHK("arAck", 1'b1, ak[0])
		`CHK("alertId", AID, byt)
		settle();
		`CHK("alertN", 1'b1, alertN)
	endtask

	////////////////////////////////////////////////
	// scenarios
	task automatic testPowerOn();
		outs(6'h00, 1'b0, 5'h0C);
		`CHK("alertN", 1'b0, alertN)
		rd();
		`CHK("stsSup", 2'h3, sts[15:14])
		`CHK("stsMst", 1'b0, sts[STS_MASTER])
		`CHK("alertN", 1'b1, alertN)
		supplyIn = 1'b0;
		settle();
		supplyIn = 1'b1;
		settle();
		`CHK("alertN", 1'b0, alertN)
		alertAck();
		$display("power-on test done");
	endtask

	task automatic testStrap();
		logic [24:0] tb [13] = '{
			{2'h0, 16'h0020, 6'h02, 1'b0}, {2'h0, 16'h03E0, 6'h3E, 1'b0},
			{2'h0, 16'h0400, 6'h3E, 1'b1}, {2'h0, 16'h0355, 6'h34, 1'b0},
			{2'h1, 16'h0020, 6'h01, 1'b0}, {2'h1, 16'h07E0, 6'h3F, 1'b0},
			{2'h1, 16'h0800, 6'h3F, 1'b1}, {2'h1, 16'h0355, 6'h1A, 1'b0},
			{2'h2, 16'h0020, 6'h01, 1'b0}, {2'h2, 16'h0040, 6'h01, 1'b0},
			{2'h2, 16'h0FC0, 6'h3F, 1'b0}, {2'h2, 16'h1000, 6'h3F, 1'b1},
			{2'h2, 16'h0355, 6'h0D, 1'b0}};
		for (int i = 0; i < 13; i++)
		begin
			strapSel = tb[i][24:23];
			wr(CMD_CURRENT, tb[i][22:7]);
			outs(tb[i][6:1], 1'b1, 5'h1F);
			rd();
			`CHK("overRange", tb[i][0], sts[STS_CUR_OR])
		end
		strapSel = STRAP_GND;
		wr(CMD_CURRENT, 16'h001F);
		outs(6'h00, 1'b0, 5'h1F);
		wr(CMD_CURRENT, 16'h0000);
		outs(6'h00, 1'b0, 5'h00);
		$display("strap test done");
	endtask

	task automatic testInhibit();
		wr(CMD_CURRENT, 16'h0400);
		underrangeIn = 1'b1;
		overheatIn = 1'b1;
		settle();
		outs(6'h3E, 1'b1, 5'h1F);
		underrangeIn = 1'b0;
		settle();
		outs(6'h3E, 1'b0, 5'h00);
		wr(CMD_CURRENT, 16'h0020);
		overheatIn = 1'b0;
		settle();
		outs(6'h3E, 1'b0, 5'h00);
		rd();
		`CHK("stsHot", 1'b1, sts[STS_HOT])
		wr(CMD_MODE, 16'h0444);
		outs(6'h00, 1'b0, 5'h0C);
		rd();
		`CHK("stsHot", 1'b0, sts[STS_HOT])
		wr(CMD_CURRENT, 16'h0400);
		wr(CMD_MODE, 16'h0441);
		outs(6'h3E, 1'b0, 5'h00);
		wr(CMD_MODE, MODE_RST);
		outs(6'h3E, 1'b1, 5'h1F);
		$display("inhibit test done");
	endtask

	task automatic testAlarm();
		logic [15:0] aw [3] = '{16'h8000, 16'h4000, 16'h1000};
		wr(CMD_ALARM, 16'h2FFF);
		outs(6'h3E, 1'b1, 5'h1F);
		for (int i = 0; i < 3; i++)
		begin
			wr(CMD_ALARM, aw[i]);
			outs(6'h3E, 1'b0, 5'h00);
			rd();
			`CHK("stsLock", 1'b1, sts[STS_LOCKOUT])
			if (i == 2)
			begin
				packDetect = 1'b0;
				settle();
				`CHK("alertN", 1'b0, alertN)
				outs(6'h00, 1'b0, 5'h0C);
				packDetect = 1'b1;
				settle();
				alertAck();
			end
			else
			begin
				wr(CMD_MODE, 16'h0444);
				outs(6'h00, 1'b0, 5'h0C);
			end
			wr(CMD_CURRENT, 16'h0400);
			outs(6'h3E, 1'b1, 5'h1F);
		end
		$display("alarm test done");
	endtask

	task automatic testAlertMask();
		inputLow = 1'b1;
		settle();
		`CHK("alertN", 1'b1, alertN)
		wr(CMD_MODE, 16'h0400);
		inputLow = 1'b0;
		settle();
		`CHK("alertN", 1'b0, alertN)
		rd();
		`CHK("alertN", 1'b1, alertN)
		wr(CMD_MODE, 16'h0420);
		packDetect = 1'b0;
		settle();
		`CHK("alertN", 1'b1, alertN)
		packDetect = 1'b1;
		settle();
		$display("alert mask test done");
	endtask

	task automatic testRefuse();
		ccca_host_model_inst.writeWord(8'h20, CMD_CURRENT, 16'h0400, ak);
		`CHK("badAddr", 1'b0, ak[3])
		settle();
		outs(6'h00, 1'b0, 5'h0C);
		ccca_host_model_inst.readWord({DEV_ADDR, 1'b0}, CMD_CURRENT, sts, ak3);
		`CHK("badRead", 1'b0, ak3[0])
		$display("refusal test done");
	endtask

	////////////////////////////////////////////////
	// verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (8) @(negedge mclk);
		testPowerOn();
		testStrap();
		testInhibit();
		testAlarm();
		testAlertMask();
		testRefuse();
		conclude();
	end
endmodule
